// ---- design/audio_gain_routing_regs.sv ----
`timescale 1ns/100ps

// What this block does
// - Cell amp powerdown bit resets to 1; 1 powers down, 0 powers up.
// - Seven-bit cell gain, 0.5 dB steps, reset 0 dB; codes above max give 12 dB.
// - With cell AGC on, cell gain field is read-only and returns applied gain.
// - Cell done flag is 1 when applied gain equals setting clamped to max, else 0.
// - With cell AGC on, the flag reports saturation at minimum or maximum gain.
// - Buzzer amp powerdown bit resets to 1; 1 powers down, 0 powers up.
// - Four-bit buzzer gain, reset 1111 is 0 dB, 3 dB per code down.
// - Buzzer done flag is 1 when applied buzzer gain equals setting.
// - Input gain bit zero is reserved, reads 0; software writes 0.
// - Style bit resets 0 single-ended; 1 makes driver one differential.
// - Differential needs both drivers powered, else both are powered down.
// - Two-bit DAC source for driver one: none, left, right, average.
// - Sidetone, buzzer, keyclick, cell input enables for driver one, reset 0.
// - Two-bit DAC source for driver two, single-ended only.
// - Four source enables for driver two, reset 0, single-ended only.
// - Driver one mute resets 1; writing 0 unmutes it.
// - Driver two mute resets 1; writing 0 unmutes, single-ended only.
// - Write-only headphone protect-off bit resets 0, meaning protection on.
// - Soft-step moves cell gain 0.5 dB, buzzer 3 dB each reference period.
module audio_gain_routing_regs #(
	parameter int STEP_CYCLES = audio_gain_routing_pkg::STEP_CYCLES
) (
	input  wire logic        i_clk_sys,        // System clock, 100 MHz
	input  wire logic        i_rst_n,          // Async reset, active low
	input  wire logic        i_clk_en,         // Freezes all state when low
	input  wire logic [7:0]  i_addr,           // Register address
	input  wire logic [15:0] i_wdata,          // Write data
	input  wire logic        i_wr,             // Write strobe
	input  wire logic        i_rd,             // Read strobe
	output logic      [15:0] o_rdata,          // Read data, cycle after i_rd
	input  wire logic        i_cell_agc_en,    // Cell input AGC enabled
	input  wire logic [6:0]  i_cell_agc_gain,  // Gain applied by AGC loop
	input  wire logic        i_cell_step_off,  // Cell soft-step disabled
	input  wire logic        i_buz_step_off,   // Buzzer soft-step disabled
	input  wire logic        i_one_power_req,  // Driver one powered up
	input  wire logic        i_inv_power_req,  // Inverting driver powered up
	input  wire logic        i_two_power_req,  // Driver two powered up
	output logic             o_cell_amp_powerdown,  // Cell amp power-down
	output logic      [6:0]  o_cell_gain_applied,   // Applied cell gain code
	output logic             o_buzzer_amp_powerdown, // Buzzer amp power-down
	output logic      [3:0]  o_buzzer_gain_applied, // Applied buzzer code
	output logic             o_differential_select, // Differential drive
	output audio_gain_routing_pkg::out_route_t o_route_one, // Driver one
	output audio_gain_routing_pkg::out_route_t o_route_two, // Driver two
	output logic             o_one_power,      // Driver one enabled
	output logic             o_inv_power,      // Inverting driver enabled
	output logic             o_two_power,      // Driver two enabled
	output logic             o_headphone_short_protect_off // Protection off
);

	// Step engine states; one bit differs between them, so the
	// usual idle-move-idle path stays a Gray sequence
	typedef enum logic [1:0] {
		STEP_IDLE = 2'b00,
		STEP_MOVE = 2'b01
	} step_state_t;

	// Software-visible settings of the gain register
	logic        cell_amp_powerdown;
	logic [6:0]  cell_gain_setting;
	logic        buzzer_amp_powerdown;
	logic [3:0]  buzzer_gain_setting;

	// Gains the amplifiers really see
	logic [6:0]  cell_gain_applied;
	logic [3:0]  buzzer_gain_applied;

	// Routing word, stored as written
	logic [15:0] route_reg;

	// Reference period pacing
	logic [15:0] tick_count;
	logic        tick;

	// Decoded write strobes
	logic        wr_gain;
	logic        wr_route;

	// Gain compare and flag terms
	logic [6:0]  cell_target;
	logic        cell_done_flag;
	logic        buzzer_done_flag;
	logic        cell_flag_read;
	logic [6:0]  cell_gain_read;
	logic        cell_saturated;

	// Differential power pairing
	logic        diff_ok;

	// Step engine states
	step_state_t cell_state;
	step_state_t buz_state;

	// Read mux output
	logic [15:0] next_rdata;

	// Write decode; a strobe to any other address is dropped here,
	// so unmapped writes cannot disturb either register

	assign wr_gain  = i_wr && i_addr == audio_gain_routing_pkg::ADDR_INPUT_GAIN;
	assign wr_route = i_wr
		&& i_addr == audio_gain_routing_pkg::ADDR_SPEAKER_ROUTE;

	// Gain register, writable bits; flags and bit zero never stored.
	// The flags are worked out at read time, and bit zero has no
	// storage, so a stray one written there never reads back.
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cell_amp_powerdown   <= 1'b1;
			cell_gain_setting    <= audio_gain_routing_pkg::CELL_GAIN_RESET;
			buzzer_amp_powerdown <= 1'b1;
			buzzer_gain_setting  <= audio_gain_routing_pkg::BUZ_GAIN_RESET;
		end
		else if (i_clk_en && wr_gain)
		begin
			cell_amp_powerdown <= i_wdata[audio_gain_routing_pkg::CELL_PD_BIT];
			// Gain field is frozen while the AGC loop owns the amplifier
			if (!i_cell_agc_en)
				cell_gain_setting <=
					i_wdata[audio_gain_routing_pkg::CELL_GAIN_LSB +: 7];
			buzzer_amp_powerdown <= i_wdata[audio_gain_routing_pkg::BUZ_PD_BIT];
			buzzer_gain_setting  <=
				i_wdata[audio_gain_routing_pkg::BUZ_GAIN_LSB +: 4];
		end
	end

	// Routing register; every bit resets per its documented value.
	// Bit zero is write-only: it is stored to drive the protection
	// control, but masked from every read.
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			route_reg <= 16'h0006;
		else if (i_clk_en && wr_route)
			route_reg <= i_wdata;
	end

	// Reference sample-period tick paces the soft-step.
	// The divider runs free and is not restarted by a write, so the
	// first step after a change lands anywhere within one period.
	// Sixteen bits leave room for faster system clocks.
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			tick_count <= 16'h0000;
		else if (i_clk_en)
			tick_count <= tick ? 16'h0000 : tick_count + 16'h0001;
	end
	assign tick = tick_count == 16'(STEP_CYCLES - 1);

	// Codes above the top effective code all behave as +12 dB.
	// The stored code is kept as written so software reads it back;
	// only the step target is clamped.
	assign cell_target =
		(cell_gain_setting > audio_gain_routing_pkg::CELL_GAIN_MAX)
		? audio_gain_routing_pkg::CELL_GAIN_MAX : cell_gain_setting;

	// Cell soft-step: one code (0.5 dB) per tick, or jump when disabled.
	// The idle state costs one cycle of latency, but a fresh target
	// is then always seen whole before the first step.
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cell_gain_applied <= audio_gain_routing_pkg::CELL_GAIN_RESET;
			cell_state        <= STEP_IDLE;
		end
		else if (i_clk_en)
		begin
			case (cell_state)
				STEP_IDLE:
				begin
					if (cell_gain_applied != cell_target)
						cell_state <= STEP_MOVE;
				end
				STEP_MOVE:
				begin
					if (i_cell_step_off)
						cell_gain_applied <= cell_target;
					else if (tick && cell_gain_applied < cell_target)
						cell_gain_applied <= cell_gain_applied + 7'h01;
					else if (tick && cell_gain_applied > cell_target)
						cell_gain_applied <= cell_gain_applied - 7'h01;
					if (cell_gain_applied == cell_target)
						cell_state <= STEP_IDLE;
				end
				default: cell_state <= STEP_IDLE;
			endcase
		end
	end

	// Buzzer soft-step: one code (3 dB) per tick.
	// Same engine as the cell path; a full sweep of sixteen codes
	// takes fifteen reference periods.
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			buzzer_gain_applied <= audio_gain_routing_pkg::BUZ_GAIN_RESET;
			buz_state           <= STEP_IDLE;
		end
		else if (i_clk_en)
		begin
			case (buz_state)
				STEP_IDLE:
				begin
					if (buzzer_gain_applied != buzzer_gain_setting)
						buz_state <= STEP_MOVE;
				end
				STEP_MOVE:
				begin
					if (i_buz_step_off)
						buzzer_gain_applied <= buzzer_gain_setting;
					else if (tick && buzzer_gain_applied < buzzer_gain_setting)
						buzzer_gain_applied <= buzzer_gain_applied + 4'h1;
					else if (tick && buzzer_gain_applied > buzzer_gain_setting)
						buzzer_gain_applied <= buzzer_gain_applied - 4'h1;
					if (buzzer_gain_applied == buzzer_gain_setting)
						buz_state <= STEP_IDLE;
				end
				default: buz_state <= STEP_IDLE;
			endcase
		end
	end

	// Completion flags follow the comparison, so a changing write drops
	// them at once and they rise only on reaching the new target
	// The flags hold no state, so no set and clear can collide
	assign cell_done_flag   = cell_gain_applied == cell_target;
	assign buzzer_done_flag = buzzer_gain_applied == buzzer_gain_setting;

	// Under AGC the flag shows saturation at either end of the range.
	// The loop's code is taken straight from its port, so the flag
	// and the read gain always agree within one cycle.
	assign cell_saturated =
		i_cell_agc_gain == audio_gain_routing_pkg::CELL_GAIN_MIN
		|| i_cell_agc_gain >= audio_gain_routing_pkg::CELL_GAIN_MAX;
	assign cell_flag_read = i_cell_agc_en ? cell_saturated : cell_done_flag;
	assign cell_gain_read = i_cell_agc_en ? i_cell_agc_gain
		: cell_gain_setting;

	// Read mux; unmapped addresses read zero, write-only bit reads zero.
	// Software can compare a read with what it wrote after masking
	// the reserved, write-only and flag bits, and the cell gain field while AGC is on.
	always_comb
	begin
		next_rdata = 16'h0000;
		case (i_addr)
			audio_gain_routing_pkg::ADDR_INPUT_GAIN:
			begin
				next_rdata = {cell_amp_powerdown, cell_gain_read,
					cell_flag_read, buzzer_amp_powerdown,
					buzzer_gain_setting, buzzer_done_flag, 1'b0};
			end
			audio_gain_routing_pkg::ADDR_SPEAKER_ROUTE:
				next_rdata = {route_reg[15:1], 1'b0};
			// Step modes, so software can see how gains will move
			audio_gain_routing_pkg::ADDR_GAIN_STEP_CTRL:
				next_rdata = {14'h0000, i_cell_step_off, i_buz_step_off};
			default: next_rdata = 16'h0000;
		endcase
	end

	// Read data registered, valid only in the cycle after the strobe.
	// Idle cycles return zero, so a stale word is never mistaken
	// for a fresh answer.
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_rdata <= 16'h0000;
		else if (i_clk_en)
			o_rdata <= i_rd ? next_rdata : 16'h0000;
	end

	// Differential pair needs both drivers up, otherwise both go down.
	// A lone powered leg would half-drive the receiver load.
	assign diff_ok = i_one_power_req && i_inv_power_req;

	// Drive outputs to the analog side.
	// All controls are registered, so the routing switches see one
	// clean change per write and no decode glitches.
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_differential_select <= 1'b0;
			o_route_one           <= '{2'b00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
			o_route_two           <= '{2'b00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
			o_one_power           <= 1'b0;
			o_inv_power           <= 1'b0;
			o_two_power           <= 1'b0;
			o_headphone_short_protect_off <= 1'b0;
		end
		else if (i_clk_en)
		begin
			o_differential_select <= route_reg[audio_gain_routing_pkg::DIFF_BIT];
			o_route_one <= '{route_reg[audio_gain_routing_pkg::DAC_ONE_LSB +: 2],
				route_reg[audio_gain_routing_pkg::SRC_ONE_LSB + 3],
				route_reg[audio_gain_routing_pkg::SRC_ONE_LSB + 2],
				route_reg[audio_gain_routing_pkg::SRC_ONE_LSB + 1],
				route_reg[audio_gain_routing_pkg::SRC_ONE_LSB],
				route_reg[audio_gain_routing_pkg::MUTE_ONE_BIT]};
			// Driver two routing is forced off and muted in differential mode
			if (route_reg[audio_gain_routing_pkg::DIFF_BIT])
				o_route_two <= '{2'b00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
			else
				o_route_two <= '{route_reg[audio_gain_routing_pkg::DAC_TWO_LSB +: 2],
					route_reg[audio_gain_routing_pkg::SRC_TWO_LSB + 3],
					route_reg[audio_gain_routing_pkg::SRC_TWO_LSB + 2],
					route_reg[audio_gain_routing_pkg::SRC_TWO_LSB + 1],
					route_reg[audio_gain_routing_pkg::SRC_TWO_LSB],
					route_reg[audio_gain_routing_pkg::MUTE_TWO_BIT]};

			// Power pairing applies only in differential mode
			if (route_reg[audio_gain_routing_pkg::DIFF_BIT])
			begin
				o_one_power <= diff_ok;
				o_inv_power <= diff_ok;
			end
			else
			begin
				o_one_power <= i_one_power_req;
				o_inv_power <= i_inv_power_req;
			end

			// Driver two power simply follows its request
			o_two_power <= i_two_power_req;
			o_headphone_short_protect_off <=
				route_reg[audio_gain_routing_pkg::HP_PROT_BIT];
		end
	end

	// Power-down bits leave straight from their registers; under the
	// loop the applied code shown is the loop's own
	assign o_cell_amp_powerdown   = cell_amp_powerdown;
	assign o_buzzer_amp_powerdown = buzzer_amp_powerdown;
	assign o_cell_gain_applied    = i_cell_agc_en ? i_cell_agc_gain
		: cell_gain_applied;
	assign o_buzzer_gain_applied  = buzzer_gain_applied;

endmodule : audio_gain_routing_regs

// ---- design/audio_gain_routing_pkg.sv ----
package audio_gain_routing_pkg;

	// Register offsets (8-bit address space)
	localparam logic [7:0] ADDR_INPUT_GAIN     = 8'h1F;
	localparam logic [7:0] ADDR_SPEAKER_ROUTE  = 8'h20;
	// Own register holding the cell and buzzer step-off inputs seen by software
	localparam logic [7:0] ADDR_GAIN_STEP_CTRL = 8'h40;

	// Input gain register field positions
	localparam int CELL_PD_BIT    = 15;
	localparam int CELL_GAIN_LSB  = 8;
	localparam int CELL_FLAG_BIT  = 7;
	localparam int BUZ_PD_BIT     = 6;
	localparam int BUZ_GAIN_LSB   = 2;
	localparam int BUZ_FLAG_BIT   = 1;

	// Speaker routing field positions
	localparam int DIFF_BIT       = 15;
	localparam int DAC_ONE_LSB    = 13;
	localparam int SRC_ONE_LSB    = 9;
	localparam int DAC_TWO_LSB    = 7;
	localparam int SRC_TWO_LSB    = 3;
	localparam int MUTE_ONE_BIT   = 2;
	localparam int MUTE_TWO_BIT   = 1;
	localparam int HP_PROT_BIT    = 0;

	// Step control register field positions
	localparam int CELL_STEP_OFF_BIT = 1;
	localparam int BUZ_STEP_OFF_BIT  = 0;

	// Reset values
	localparam logic [6:0] CELL_GAIN_RESET = 7'h45;
	localparam logic [3:0] BUZ_GAIN_RESET  = 4'hF;
	// Highest effective cell gain code (+12 dB); above it, saturates
	localparam logic [6:0] CELL_GAIN_MAX   = 7'h5D;
	localparam logic [6:0] CELL_GAIN_MIN   = 7'h00;

	// Reference sample period: 48 ksps stepping pace
	localparam int SYS_CLK_HZ     = 100_000_000;
	localparam int FS_REF_HZ      = 48_000;
	localparam int STEP_CYCLES    = SYS_CLK_HZ / FS_REF_HZ;

	// Register write value
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] data;
	} reg_access_t;

	// Speaker routing settings per driver
	typedef struct packed {
		logic [1:0] dac_source;
		logic       sidetone;
		logic       buzzer;
		logic       keyclick;
		logic       cell_in;
		logic       mute;
	} out_route_t;

endpackage : audio_gain_routing_pkg

// ---- tb/audio_gain_routing_checker.sv ----
`timescale 1ns/100ps
module audio_gain_routing_checker (
	input wire logic        i_clk_sys,              // Clock
	input wire logic        i_rst_n,                // Reset, active low
	input wire logic        i_clk_en,               // Run enable
	input wire logic [7:0]  i_addr,                 // Address
	input wire logic [15:0] i_wdata,                // Write data
	input wire logic        i_wr,                   // Write strobe
	input wire logic        i_rd,                   // Read strobe
	input wire logic [15:0] o_rdata,                // Read data
	input wire logic        i_cell_agc_en,          // Loop owns gain
	input wire logic [6:0]  i_cell_agc_gain,        // Loop code
	input wire logic        i_cell_step_off,        // Cell jumps
	input wire logic        i_buz_step_off,         // Buzzer jumps
	input wire logic        o_cell_amp_powerdown,   // Cell down
	input wire logic        o_buzzer_amp_powerdown, // Buzzer down
	input wire logic [6:0]  o_cell_gain_applied,    // Cell code
	input wire logic [3:0]  o_buzzer_gain_applied,  // Buzzer code
	input wire logic        o_differential_select,  // Diff drive
	input wire audio_gain_routing_pkg::out_route_t o_route_one, // One
	input wire audio_gain_routing_pkg::out_route_t o_route_two, // Two
	input wire logic        o_one_power,            // One on
	input wire logic        o_inv_power,            // Inverting on
	input wire logic        o_headphone_short_protect_off // Prot off
);
	logic g_hit, s_hit, wg, w20, rg;
	// Accesses the block takes; a frozen enable takes none
	assign g_hit = i_addr == audio_gain_routing_pkg::ADDR_INPUT_GAIN;
	assign s_hit = i_addr == audio_gain_routing_pkg::ADDR_SPEAKER_ROUTE;
	assign wg = i_clk_en && i_wr && g_hit;
	assign w20 = i_clk_en && i_wr && s_hit;
	assign rg = i_clk_en && i_rd && g_hit;

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	a_reserved_zero: assert property (
		(i_clk_en && i_rd && (g_hit || s_hit)) |=> !o_rdata[0])
		else $error("bit zero read back set");
	a_agc_read: assert property ((rg && i_cell_agc_en) |=>
		o_rdata[14:8] == $past(i_cell_agc_gain) && o_rdata[7] ==
		($past(i_cell_agc_gain) == 7'h00 || $past(i_cell_agc_gain) >= 7'h5D))
		else $error("loop gain or saturation read wrong");
	a_gain_pd_write: assert property (wg |=>
		o_cell_amp_powerdown == $past(i_wdata[15]) &&
		o_buzzer_amp_powerdown == $past(i_wdata[6]))
		else $error("powerdown bits not taken");
	// Routing outputs follow the stored word one edge later again
	a_route_write: assert property (w20 |=> ##1
		o_route_one == {$past(i_wdata[14:9], 2), $past(i_wdata[2], 2)} &&
		o_differential_select == $past(i_wdata[15], 2) &&
		o_headphone_short_protect_off == $past(i_wdata[0], 2))
		else $error("driver one routing not taken");
	a_route_two_set: assert property ((w20 && !i_wdata[15]) |=> ##1
		o_route_two == {$past(i_wdata[8:3], 2), $past(i_wdata[1], 2)})
		else $error("driver two routing not taken");
	a_diff_forced: assert property (o_differential_select |->
		o_route_two == 7'h01 &&
		(!$past(o_differential_select) || o_one_power == o_inv_power))
		else $error("differential drive not paired");
	a_cell_pace: assert property ((!i_cell_agc_en && !$past(i_cell_agc_en)
		&& !$past(i_cell_agc_en, 2) && !i_cell_step_off
		&& !$past(i_cell_step_off) && $changed(o_cell_gain_applied)) |->
		(o_cell_gain_applied - $past(o_cell_gain_applied)) == 7'h01 ||
		($past(o_cell_gain_applied) - o_cell_gain_applied) == 7'h01)
		else $error("cell gain moved more than one code");
	a_buz_pace: assert property ((!i_buz_step_off && !$past(i_buz_step_off)
		&& $changed(o_buzzer_gain_applied)) |->
		(o_buzzer_gain_applied - $past(o_buzzer_gain_applied)) == 4'h1 ||
		($past(o_buzzer_gain_applied) - o_buzzer_gain_applied) == 4'h1)
		else $error("buzzer gain moved more than one code");

	// Main scenarios reached
	c_agc_read: cover property (rg && i_cell_agc_en);
	c_diff_on: cover property (w20 && i_wdata[15]);
	c_buz_step: cover property ($changed(o_buzzer_gain_applied));
endmodule : audio_gain_routing_checker

bind audio_gain_routing_regs audio_gain_routing_checker u_chk (
	.i_clk_sys, .i_rst_n, .i_clk_en, .i_addr, .i_wdata, .i_wr, .i_rd,
	.o_rdata, .i_cell_agc_en, .i_cell_agc_gain, .i_cell_step_off,
	.i_buz_step_off, .o_cell_amp_powerdown, .o_buzzer_amp_powerdown,
	.o_cell_gain_applied, .o_buzzer_gain_applied, .o_differential_select,
	.o_route_one, .o_route_two, .o_one_power, .o_inv_power,
	.o_headphone_short_protect_off
);

// ---- tb/audio_gain_routing_regs_tb.sv ----
`timescale 1ns/100ps
module audio_gain_routing_regs_tb;
	localparam int STEPS = 4;
	logic        i_clk_sys, i_rst_n, i_clk_en, i_wr, i_rd, rd_seen;
	logic [7:0]  i_addr;
	logic [15:0] i_wdata, o_rdata, d;
	logic        i_cell_agc_en, i_cell_step_off, i_buz_step_off, cpd, bpd;
	logic [6:0]  i_cell_agc_gain, o_cell_gain_applied, cg;
	logic        i_one_power_req, i_inv_power_req, i_two_power_req;
	logic        o_cell_amp_powerdown, o_buzzer_amp_powerdown;
	logic [3:0]  o_buzzer_gain_applied, bg;
	logic        o_differential_select, o_one_power, o_inv_power;
	logic        o_two_power, o_headphone_short_protect_off;
	logic [2:0]  pw;
	audio_gain_routing_pkg::out_route_t o_route_one, o_route_two;
	logic [6:0]  agc_codes [4] = '{7'h00, 7'h30, 7'h5D, 7'h7F};
	logic [15:0] exp_q [$];
	int          bad_count = 0, num_checks = 0, n;

	audio_gain_routing_regs #(.STEP_CYCLES(STEPS)) uut (
		.i_clk_sys, .i_rst_n, .i_clk_en, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_cell_agc_en, .i_cell_agc_gain, .i_cell_step_off,
		.i_buz_step_off, .i_one_power_req, .i_inv_power_req,
		.i_two_power_req, .o_cell_amp_powerdown, .o_cell_gain_applied,
		.o_buzzer_amp_powerdown, .o_buzzer_gain_applied,
		.o_differential_select, .o_route_one, .o_route_two, .o_one_power,
		.o_inv_power, .o_two_power, .o_headphone_short_protect_off
	);

	// 100 MHz system clock
	initial
	begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	// Shared comparison, counts every check
	task automatic chk(input string nm, input logic [15:0] e, g);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Single exit point for normal end and hangs
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	// Bus cycles; strobes stay up so back-to-back calls never double-drive
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge i_clk_sys);
		{i_wr, i_rd, i_addr, i_wdata} <= {2'b10, a, v};
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge i_clk_sys);
		{i_wr, i_rd, i_addr} <= {2'b01, a};
		exp_q.push_back(e);
	endtask : rd
	task automatic idle();
		@(posedge i_clk_sys);
		{i_wr, i_rd} <= 2'b00;
	endtask : idle

	// Read data is looked at only in the cycle after its strobe
	always @(posedge i_clk_sys)
		rd_seen <= i_rd && i_clk_en;
	always @(negedge i_clk_sys)
		if (rd_seen === 1'b1)
			chk("rdata", exp_q.pop_front(), o_rdata);

	// Expected gain register image from the bench's own model
	function automatic logic [15:0] g1f(input logic f, input logic bf);
		return {cpd, cg, f, bpd, bg, bf, 1'b0};
	endfunction : g1f

	// Bounded wait until both applied gains reach their settings
	task automatic settle();
		n = 0;
		@(negedge i_clk_sys);
		while ((o_cell_gain_applied !== cg || o_buzzer_gain_applied !== bg)
			&& n < 500)
		begin
			@(negedge i_clk_sys);
			n++;
		end
		if (n >= 500)
		begin
			$display("[ERR] settle expected %h seen %h", cg, o_cell_gain_applied);
			bad_count++;
			final_report();
		end
	endtask : settle

	// Reset, then all outputs and registers at their initial values
	task automatic reset_check();
		@(posedge i_clk_sys);
		i_rst_n <= 1'b0;
		repeat (6) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		{cpd, bpd, cg, bg} = {2'b11, 7'h45, 4'hF};
		@(negedge i_clk_sys);
		chk("reset gains", 16'h1C5F, 16'({o_cell_amp_powerdown,
			o_buzzer_amp_powerdown, o_cell_gain_applied, o_buzzer_gain_applied}));
		chk("reset routes", 16'h0081, 16'({o_route_one, o_route_two}));
		chk("reset misc", 16'h0000, 16'({o_differential_select, o_one_power,
			o_inv_power, o_two_power, o_headphone_short_protect_off}));
		rd(audio_gain_routing_pkg::ADDR_INPUT_GAIN, g1f(1, 1));
		rd(audio_gain_routing_pkg::ADDR_SPEAKER_ROUTE, 16'h0006);
		rd(8'h55, 16'h0000);
		rd(audio_gain_routing_pkg::ADDR_GAIN_STEP_CTRL,
			16'({i_cell_step_off, i_buz_step_off}));
		idle();
		$display("test reset done");
	endtask : reset_check

	// Main sequence
	initial
	begin
		{i_rst_n, i_clk_en, i_wr, i_rd, i_addr, i_wdata} = 28'h4000000;
		{i_cell_agc_en, i_cell_agc_gain, i_cell_step_off, i_buz_step_off} = 0;
		{i_one_power_req, i_inv_power_req, i_two_power_req} = 3'h0;
		n = $urandom(10);
		reset_check();
		{cpd, bpd, cg, bg} = {2'b00, 7'h40, 4'hC};
		wr(audio_gain_routing_pkg::ADDR_INPUT_GAIN, g1f(0, 0));
		rd(audio_gain_routing_pkg::ADDR_INPUT_GAIN, g1f(0, 0));
		idle();
		settle();
		chk("step time", 16'h0001, 16'(n >= 3 * STEPS && n <= 6 * STEPS));
		rd(audio_gain_routing_pkg::ADDR_INPUT_GAIN, g1f(1, 1));
		idle();
		$display("test soft step done");
		@(posedge i_clk_sys);
		{i_cell_step_off, i_buz_step_off} <= 2'b11;
		repeat (5)
		begin
			{cpd, bpd, cg, bg} = {2'($urandom), 7'($urandom_range(93, 0)),
				4'($urandom)};
			wr(audio_gain_routing_pkg::ADDR_INPUT_GAIN, g1f(0, 0));
			idle();
			settle();
			chk("jump time", 16'h0001, 16'(n <= 3));
			rd(audio_gain_routing_pkg::ADDR_INPUT_GAIN, g1f(1, 1));
			rd(audio_gain_routing_pkg::ADDR_GAIN_STEP_CTRL, 16'h0003);
			idle();
		end
		$display("test jump done");
		@(posedge i_clk_sys);
		i_cell_agc_en <= 1'b1;
		{cpd, bpd} = 2'b11;
		foreach (agc_codes[k])
		begin
			wr(audio_gain_routing_pkg::ADDR_INPUT_GAIN,
				{cpd, ~cg, 1'b0, bpd, bg, 2'b00});
			i_cell_agc_gain <= agc_codes[k];
			rd(audio_gain_routing_pkg::ADDR_INPUT_GAIN, {cpd, agc_codes[k],
				agc_codes[k] == 7'h00 || agc_codes[k] >= 7'h5D, bpd, bg, 2'b10});
			idle();
			@(negedge i_clk_sys);
			chk("loop gain", 16'(agc_codes[k]), 16'(o_cell_gain_applied));
		end
		@(posedge i_clk_sys);
		i_cell_agc_en <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		rd(audio_gain_routing_pkg::ADDR_INPUT_GAIN, g1f(1, 1));
		idle();
		cg = 7'h7F;
		wr(audio_gain_routing_pkg::ADDR_INPUT_GAIN, g1f(0, 0));
		idle();
		repeat (3) @(negedge i_clk_sys);
		chk("clamp", 16'h005D, 16'(o_cell_gain_applied));
		$display("test loop and clamp done");
		repeat (6)
		begin
			d = 16'($urandom) & 16'h7FFF;
			wr(audio_gain_routing_pkg::ADDR_SPEAKER_ROUTE, d);
			rd(audio_gain_routing_pkg::ADDR_SPEAKER_ROUTE, d & 16'hFFFE);
			idle();
			@(negedge i_clk_sys);
			chk("route one", 16'({d[14:9], d[2]}), 16'(o_route_one));
			chk("route two", 16'({d[8:3], d[1]}), 16'(o_route_two));
			chk("diff prot", 16'({1'b0, d[0]}), 16'({o_differential_select,
				o_headphone_short_protect_off}));
		end
		for (int m = 0; m < 16; m++)
		begin
			wr(audio_gain_routing_pkg::ADDR_SPEAKER_ROUTE, {m[3], 15'h0006});
			{i_one_power_req, i_inv_power_req, i_two_power_req} <= m[2:0];
			idle();
			repeat (3) @(negedge i_clk_sys);
			pw = m[3] ? {{2{m[2] & m[1]}}, m[0]} : m[2:0];
			chk("powers", 16'(pw), 16'({o_one_power, o_inv_power, o_two_power}));
			if (m[3])
				chk("diff two", 16'h0001, 16'(o_route_two));
		end
		$display("test routing done");
		@(posedge i_clk_sys);
		i_clk_en <= 1'b0;
		wr(audio_gain_routing_pkg::ADDR_SPEAKER_ROUTE, 16'h0001);
		idle();
		@(posedge i_clk_sys);
		i_clk_en <= 1'b1;
		@(negedge i_clk_sys);
		chk("frozen", 16'h0002, 16'({o_differential_select,
			o_headphone_short_protect_off}));
		$display("test freeze done");
		reset_check();
		final_report();
	end
endmodule : audio_gain_routing_regs_tb
